// ---- src/pgs_top.sv ----
// Upper port data latch, lower port pin interrupt and serial pin port registers behind APB.
// Assumes direction control for the upper port comes from a neighbouring register on this clock,
// and that pin levels arrive asynchronously and are resolved to wires by the surroundings.
//
// Overview of operation
// - Upper latch drives pins set as output
// - Input bits read synchronised pin level
// - Output bits read back latched value
// - Upper latch is never reset
// - Enable register cleared only by power-on
// - Enabled low lower pin requests interrupt
// - Interrupt is OR of enabled pins
// - Enable bit selects pin interrupt source
// - Serial one clears all but bits 2,0
// - Serial port registers always accessible
// - Reserved bits six to four read zero
// - Bit seven gates serial receive interrupt
// - Clock direction bit drives clock data
// - Clock data bit reads clock pin
// - Transmit direction bit drives break data
// - Break data bit reads receive pin
// - Pin data bits: 0 low, 1 high
// - Second register drives request-to-send pin
// - Second register clears all but 6,4,2,0
`timescale 1ns/1ns
module pgs_top #(
	parameter int PORT_W = 16                       // Width of upper and lower ports
) (
	// Clock and resets
	input  wire logic                 clock,
	input  wire logic                 rst,          // Power-on reset
	input  wire logic                 manual_rst,   // Manual reset
	// APB slave
	input  wire pgs_pkg::pgs_apb_req_t apb_req,
	output logic                      pready,
	output logic [31:0]               prdata,
	output logic                      pslverr,
	// Pin inputs, asynchronous
	input  wire pgs_pkg::pgs_pin_in_t  pin_in,
	// Upper port direction from its control register
	input  wire logic [PORT_W-1:0]    upper_dir,
	// Upper port pin drive
	output logic [PORT_W-1:0]         upper_pin_out,
	output logic [PORT_W-1:0]         upper_pin_oe,
	// Lower port interrupt
	output logic [PORT_W-1:0]         lower_irq_mode,
	output logic                      pin_irq,
	// Serial interface one cooperation
	input  wire logic                 receive_irq_req,
	output logic                      receive_irq,
	output logic                      error_irq_only_select,
	// Serial interface one pins
	output logic                      sck1_out,
	output logic                      sck1_oe,
	output logic                      txd1_out,
	output logic                      txd1_oe,
	// Serial interface two pins
	output logic                      rts2_out,
	output logic                      rts2_oe,
	output logic                      cts2_out,
	output logic                      cts2_oe,
	output logic                      sck2_out,
	output logic                      sck2_oe,
	output logic                      txd2_out,
	output logic                      txd2_oe
);

	// Synchroniser stages and filtered pin levels
	logic [pgs_pkg::PIN_IN_W-1:0] sync_s1;        // First stage, read only by second
	logic [pgs_pkg::PIN_IN_W-1:0] sync_s2;        // Second stage
	logic [pgs_pkg::PIN_IN_W-1:0] sync_s3;        // Third stage
	logic [pgs_pkg::PIN_IN_W-1:0] pin_filt;       // Accepted pin levels
	pgs_pkg::pgs_pin_in_t         pin_lvl;        // Accepted levels as a struct

	// Register contents
	logic [PORT_W-1:0]            upper_port_data_latch;  // Not reset
	logic [PORT_W-1:0]            pin_interrupt_enable;   // Power-on reset only
	logic                         sp1_eio;                // Receive interrupt gate
	logic                         sp1_clk_dir;            // Clock pin direction
	logic                         sp1_clk_data;           // Clock pin data, not reset
	logic                         sp1_tx_dir;             // Transmit pin direction
	logic                         sp1_brk_data;           // Break data, not reset
	logic                         sp2_rts_dir;            // Request-to-send direction
	logic                         sp2_rts_data;           // Not reset
	logic                         sp2_cts_dir;            // Clear-to-send direction
	logic                         sp2_cts_data;           // Not reset
	logic                         sp2_clk_dir;            // Second clock direction
	logic                         sp2_clk_data;           // Not reset
	logic                         sp2_tx_dir;             // Second transmit direction
	logic                         sp2_brk_data;           // Not reset

	// Bus decode
	logic                         setup_phase;    // Setup cycle seen
	logic                         wr_fire;        // Write takes effect
	logic                         sel_upper;      // Address hits upper latch
	logic                         sel_irq_en;     // Address hits enable register
	logic                         sel_sp1;        // Address hits serial one
	logic                         sel_sp2;        // Address hits serial two
	logic [31:0]                  next_prdata;    // Read data for this address
	logic                         next_pslverr;   // Unmapped address flag
	logic [PORT_W-1:0]            upper_rd;       // Upper port read view
	logic [PORT_W-1:0]            lane_mask;      // Byte lanes for 16-bit registers
	logic [PORT_W-1:0]            next_upper;     // Upper latch after write

	// Three-stage pin synchroniser
	// First stage may go metastable; only the second reads it
	always_ff @(posedge clock) begin
		sync_s1 <= pin_in;
		sync_s2 <= sync_s1;
		sync_s3 <= sync_s2;
	end

	// Accept a level once second and third stages agree
	// A one-clock flicker on a pin is never accepted
	// Starts high, the idle level of a pulled-up pin
	generate
		for (genvar i = 0; i < pgs_pkg::PIN_IN_W; i++) begin : g_filt
			always_ff @(posedge clock) begin
				if (rst) begin
					pin_filt[i] <= 1'b1;
				end else if (sync_s2[i] == sync_s3[i]) begin
					pin_filt[i] <= sync_s3[i];
				end
			end
		end
	endgenerate

	// Struct view of accepted levels
	// Same bit order as the pin input struct
	assign pin_lvl = pin_filt;

	// Bus phase and address decode
	// Exact byte offsets only; anything else is refused
	assign setup_phase = apb_req.psel & ~apb_req.penable;
	assign wr_fire     = apb_req.psel & apb_req.penable & pready & apb_req.pwrite;
	assign sel_upper   = (apb_req.paddr == pgs_pkg::OFS_UPPER_LATCH);
	assign sel_irq_en  = (apb_req.paddr == pgs_pkg::OFS_PIN_IRQ_EN);
	assign sel_sp1     = (apb_req.paddr == pgs_pkg::OFS_SERIAL_ONE);
	assign sel_sp2     = (apb_req.paddr == pgs_pkg::OFS_SERIAL_TWO);
	assign lane_mask   = {{8{apb_req.pstrb[1]}}, {8{apb_req.pstrb[0]}}};

	// Upper port read view: inputs show pin, outputs show latch
	assign upper_rd = (upper_dir & upper_port_data_latch) | (~upper_dir & pin_lvl.upper_pin);

	// Upper latch value after a strobed write
	assign next_upper = (upper_port_data_latch & ~lane_mask) | (apb_req.pwdata[PORT_W-1:0] & lane_mask);

	// Read data and error for the addressed register
	// Pin bits show the accepted level at the setup edge
	always_comb begin
		next_prdata  = 32'h0000_0000;
		next_pslverr = 1'b0;
		if (sel_upper) begin
			next_prdata[PORT_W-1:0] = upper_rd;
		end else if (sel_irq_en) begin
			next_prdata[PORT_W-1:0] = pin_interrupt_enable;
		end else if (sel_sp1) begin
			// Reserved bits six to four stay zero
			next_prdata[pgs_pkg::SP1_EIO_BIT]      = sp1_eio;
			next_prdata[pgs_pkg::SP1_CLK_DIR_BIT]  = sp1_clk_dir;
			next_prdata[pgs_pkg::SP1_CLK_DATA_BIT] = pin_lvl.sck1_pin;
			next_prdata[pgs_pkg::SP1_TX_DIR_BIT]   = sp1_tx_dir;
			next_prdata[pgs_pkg::SP1_BRK_DATA_BIT] = pin_lvl.rxd1_pin;
		end else if (sel_sp2) begin
			// Data bits read their pin whatever the direction
			next_prdata[pgs_pkg::SP2_RTS_DIR_BIT]  = sp2_rts_dir;
			next_prdata[pgs_pkg::SP2_RTS_DATA_BIT] = pin_lvl.rts2_pin;
			next_prdata[pgs_pkg::SP2_CTS_DIR_BIT]  = sp2_cts_dir;
			next_prdata[pgs_pkg::SP2_CTS_DATA_BIT] = pin_lvl.cts2_pin;
			next_prdata[pgs_pkg::SP2_CLK_DIR_BIT]  = sp2_clk_dir;
			next_prdata[pgs_pkg::SP2_CLK_DATA_BIT] = pin_lvl.sck2_pin;
			next_prdata[pgs_pkg::SP2_TX_DIR_BIT]   = sp2_tx_dir;
			next_prdata[pgs_pkg::SP2_BRK_DATA_BIT] = pin_lvl.rxd2_pin;
		end else begin
			// Unmapped address
			next_pslverr = 1'b1;
		end
	end

	// Ready one cycle after setup, so every access has no wait state
	// Drops after one cycle, so a back-to-back setup is seen
	always_ff @(posedge clock) begin
		if (rst) begin
			pready <= 1'b0;
		end else begin
			pready <= setup_phase;
		end
	end

	// Capture read data and error during setup
	// Held until the next setup for a late sampler
	always_ff @(posedge clock) begin
		if (rst) begin
			prdata  <= 32'h0000_0000;
			pslverr <= 1'b0;
		end else if (setup_phase) begin
			prdata  <= apb_req.pwrite ? 32'h0000_0000 : next_prdata;
			pslverr <= next_pslverr;
		end
	end

	// Upper latch: written by software, untouched by any reset
	// Unknown until written; write it before making bits outputs
	always_ff @(posedge clock) begin
		if (wr_fire && sel_upper) begin
			upper_port_data_latch <= next_upper;
		end
	end

	// Pin interrupt enable: power-on reset only, kept over manual reset
	// Lower pin direction lives outside this block
	always_ff @(posedge clock) begin
		if (rst) begin
			pin_interrupt_enable <= pgs_pkg::RST_PIN_IRQ_EN;
		end else if (wr_fire && sel_irq_en) begin
			pin_interrupt_enable <= (pin_interrupt_enable & ~lane_mask) | (apb_req.pwdata[PORT_W-1:0] & lane_mask);
		end
	end

	// Serial one control bits, cleared by either reset
	// Bits six to four have no storage and read zero
	always_ff @(posedge clock) begin
		if (rst || manual_rst) begin
			sp1_eio     <= pgs_pkg::RST_SP_CTRL_BIT;
			sp1_clk_dir <= pgs_pkg::RST_SP_CTRL_BIT;
			sp1_tx_dir  <= pgs_pkg::RST_SP_CTRL_BIT;
		end else if (wr_fire && sel_sp1 && apb_req.pstrb[0]) begin
			sp1_eio     <= apb_req.pwdata[pgs_pkg::SP1_EIO_BIT];
			sp1_clk_dir <= apb_req.pwdata[pgs_pkg::SP1_CLK_DIR_BIT];
			sp1_tx_dir  <= apb_req.pwdata[pgs_pkg::SP1_TX_DIR_BIT];
		end
	end

	// Serial one data bits, left undefined by reset
	// Reads return the pins, so these matter only when driving
	always_ff @(posedge clock) begin
		if (wr_fire && sel_sp1 && apb_req.pstrb[0]) begin
			sp1_clk_data <= apb_req.pwdata[pgs_pkg::SP1_CLK_DATA_BIT];
			sp1_brk_data <= apb_req.pwdata[pgs_pkg::SP1_BRK_DATA_BIT];
		end
	end

	// Serial two direction bits, cleared by either reset
	// Only byte lane zero carries these fields
	always_ff @(posedge clock) begin
		if (rst || manual_rst) begin
			sp2_rts_dir <= pgs_pkg::RST_SP_CTRL_BIT;
			sp2_cts_dir <= pgs_pkg::RST_SP_CTRL_BIT;
			sp2_clk_dir <= pgs_pkg::RST_SP_CTRL_BIT;
			sp2_tx_dir  <= pgs_pkg::RST_SP_CTRL_BIT;
		end else if (wr_fire && sel_sp2 && apb_req.pstrb[0]) begin
			sp2_rts_dir <= apb_req.pwdata[pgs_pkg::SP2_RTS_DIR_BIT];
			sp2_cts_dir <= apb_req.pwdata[pgs_pkg::SP2_CTS_DIR_BIT];
			sp2_clk_dir <= apb_req.pwdata[pgs_pkg::SP2_CLK_DIR_BIT];
			sp2_tx_dir  <= apb_req.pwdata[pgs_pkg::SP2_TX_DIR_BIT];
		end
	end

	// Serial two data bits, left undefined by reset
	always_ff @(posedge clock) begin
		if (wr_fire && sel_sp2 && apb_req.pstrb[0]) begin
			sp2_rts_data <= apb_req.pwdata[pgs_pkg::SP2_RTS_DATA_BIT];
			sp2_cts_data <= apb_req.pwdata[pgs_pkg::SP2_CTS_DATA_BIT];
			sp2_clk_data <= apb_req.pwdata[pgs_pkg::SP2_CLK_DATA_BIT];
			sp2_brk_data <= apb_req.pwdata[pgs_pkg::SP2_BRK_DATA_BIT];
		end
	end

	// Upper port pin drive, latch value where the bit is an output
	// Enable trails the direction input by one clock
	always_ff @(posedge clock) begin
		if (rst) begin
			upper_pin_oe <= '0;
		end else begin
			upper_pin_oe <= upper_dir;
		end
	end

	// Pin value follows the latch; undefined until first written
	// Seen on the pin only where the enable is high
	always_ff @(posedge clock) begin
		upper_pin_out <= upper_port_data_latch;
	end

	// Per-pin interrupt source select for the lower port
	always_ff @(posedge clock) begin
		if (rst) begin
			lower_irq_mode <= '0;
		end else begin
			lower_irq_mode <= pin_interrupt_enable;
		end
	end

	// Active-low level interrupt, OR over enabled pins
	// No source flag is kept; software reads the lower port
	// About five clocks from pin change to request
	always_ff @(posedge clock) begin
		if (rst) begin
			pin_irq <= 1'b0;
		end else begin
			pin_irq <= |(pin_interrupt_enable & ~pin_lvl.lower_pin);
		end
	end

	// Receive interrupt passes only while error-only select is clear
	// Request comes from this clock, so it needs no filter
	always_ff @(posedge clock) begin
		if (rst) begin
			receive_irq           <= 1'b0;
			error_irq_only_select <= 1'b0;
		end else begin
			receive_irq           <= receive_irq_req & ~sp1_eio;
			error_irq_only_select <= sp1_eio;
		end
	end

	// Serial one pin enables
	// A cleared direction bit releases the pin
	always_ff @(posedge clock) begin
		if (rst) begin
			sck1_oe <= 1'b0;
			txd1_oe <= 1'b0;
		end else begin
			sck1_oe <= sp1_clk_dir;
			txd1_oe <= sp1_tx_dir;
		end
	end

	// Serial one pin values, high level for a one
	// Valid only while the matching enable is high
	always_ff @(posedge clock) begin
		if (rst) begin
			sck1_out <= 1'b0;
			txd1_out <= 1'b0;
		end else begin
			sck1_out <= sp1_clk_data;
			txd1_out <= sp1_brk_data;
		end
	end

	// Serial two pin enables
	// Cleared by either reset, as the direction bits are
	always_ff @(posedge clock) begin
		if (rst) begin
			rts2_oe <= 1'b0;
			cts2_oe <= 1'b0;
			sck2_oe <= 1'b0;
			txd2_oe <= 1'b0;
		end else begin
			rts2_oe <= sp2_rts_dir;
			cts2_oe <= sp2_cts_dir;
			sck2_oe <= sp2_clk_dir;
			txd2_oe <= sp2_tx_dir;
		end
	end

	// Serial two pin values
	// One drives a high level, zero a low level
	always_ff @(posedge clock) begin
		if (rst) begin
			rts2_out <= 1'b0;
			cts2_out <= 1'b0;
			sck2_out <= 1'b0;
			txd2_out <= 1'b0;
		end else begin
			rts2_out <= sp2_rts_data;
			cts2_out <= sp2_cts_data;
			sck2_out <= sp2_clk_data;
			txd2_out <= sp2_brk_data;
		end
	end

endmodule

// ---- src/pgs_pkg.sv ----
// Package for the upper port data latch, pin interrupt enable and serial pin port block.
// Assumes a 32-bit APB slave and a single 50 MHz clock; all offsets are byte addresses.
package pgs_pkg;
	// Register byte offsets
	localparam logic [7:0]  OFS_UPPER_LATCH   = 8'h00;
	localparam logic [7:0]  OFS_PIN_IRQ_EN    = 8'h04;
	localparam logic [7:0]  OFS_SERIAL_ONE    = 8'h08;
	localparam logic [7:0]  OFS_SERIAL_TWO    = 8'h0C;
	// Reset value of the pin interrupt enable register
	localparam logic [15:0] RST_PIN_IRQ_EN    = 16'h0000;
	// Reset value of the resettable serial port control bits
	localparam logic        RST_SP_CTRL_BIT   = 1'b0;
	// Serial pin port one field positions
	localparam int          SP1_EIO_BIT       = 7;
	localparam int          SP1_CLK_DIR_BIT   = 3;
	localparam int          SP1_CLK_DATA_BIT  = 2;
	localparam int          SP1_TX_DIR_BIT    = 1;
	localparam int          SP1_BRK_DATA_BIT  = 0;
	// Serial pin port two field positions
	localparam int          SP2_RTS_DIR_BIT   = 7;
	localparam int          SP2_RTS_DATA_BIT  = 6;
	localparam int          SP2_CTS_DIR_BIT   = 5;
	localparam int          SP2_CTS_DATA_BIT  = 4;
	localparam int          SP2_CLK_DIR_BIT   = 3;
	localparam int          SP2_CLK_DATA_BIT  = 2;
	localparam int          SP2_TX_DIR_BIT    = 1;
	localparam int          SP2_BRK_DATA_BIT  = 0;
	// Number of synchronised pin inputs
	localparam int          PIN_IN_W          = 38;

	// APB request from the master
	typedef struct packed {
		logic        psel;
		logic        penable;
		logic        pwrite;
		logic [7:0]  paddr;
		logic [31:0] pwdata;
		logic [3:0]  pstrb;
	} pgs_apb_req_t;

	// External pin levels entering the block
	typedef struct packed {
		logic [15:0] upper_pin;
		logic [15:0] lower_pin;
		logic        sck1_pin;
		logic        rxd1_pin;
		logic        rts2_pin;
		logic        cts2_pin;
		logic        sck2_pin;
		logic        rxd2_pin;
	} pgs_pin_in_t;
endpackage

// ---- verification/pgs_top_asserts.sv ----
// Checker for the port block: bus timing, pin drive and interrupt relations.
// Assumes it is bound into pgs_top and sees only that module's ports.
`timescale 1ns/1ns
module pgs_top_asserts #(
	parameter int PORT_W = 16                        // Port width, as in the design
) (
	// Clock and resets
	input wire logic                  clock,
	input wire logic                  rst,
	input wire logic                  manual_rst,
	// Bus
	input wire pgs_pkg::pgs_apb_req_t apb_req,
	input wire logic                  pready,
	input wire logic [31:0]           prdata,
	input wire logic                  pslverr,
	// Pins and interrupts
	input wire pgs_pkg::pgs_pin_in_t  pin_in,
	input wire logic [PORT_W-1:0]     upper_pin_out,
	input wire logic [PORT_W-1:0]     lower_irq_mode,
	input wire logic                  pin_irq,
	input wire logic                  receive_irq_req,
	input wire logic                  receive_irq,
	input wire logic                  error_irq_only_select,
	input wire logic                  sck1_out,
	input wire logic                  sck1_oe,
	input wire logic                  txd1_out,
	input wire logic                  txd1_oe,
	input wire logic                  rts2_out,
	input wire logic                  rts2_oe
);
	// Completed write not overlapped by a manual reset
	logic wr_done;
	assign wr_done = apb_req.psel && apb_req.penable && pready && apb_req.pwrite && !manual_rst;
	default clocking cb @(posedge clock); endclocking
	default disable iff (rst);
	a_ready_after_setup: assert property (apb_req.psel && !apb_req.penable |=> pready && !$past(pready))
		else $error("pready not raised once after setup");
	a_upper_drive_latch: assert property (wr_done && apb_req.paddr == pgs_pkg::OFS_UPPER_LATCH
		|-> ##2 upper_pin_out == $past(apb_req.pwdata[PORT_W-1:0], 2)) else $error("upper pins miss latch");
	a_irq_low_pin: assert property (($stable(lower_irq_mode) && $stable(pin_in.lower_pin)
		&& (lower_irq_mode & ~pin_in.lower_pin) != '0)[*7] |-> pin_irq) else $error("enabled low pin gives no interrupt");
	a_irq_masked_off: assert property (($stable(lower_irq_mode) && $stable(pin_in.lower_pin)
		&& (lower_irq_mode & ~pin_in.lower_pin) == '0)[*7] |-> !pin_irq) else $error("interrupt without enabled low pin");
	a_rx_irq_gate: assert property (!$past(rst) && $stable(error_irq_only_select)
		|-> receive_irq == ($past(receive_irq_req) && !error_irq_only_select)) else $error("receive irq gate wrong");
	a_sp1_pin_drive: assert property (wr_done && apb_req.paddr == pgs_pkg::OFS_SERIAL_ONE ##1 !manual_rst
		|-> ##1 {sck1_oe, sck1_out, txd1_oe, txd1_out} == $past(apb_req.pwdata[3:0], 2))
		else $error("serial one pins miss register");
	a_sp2_rts_drive: assert property (wr_done && apb_req.paddr == pgs_pkg::OFS_SERIAL_TWO ##1 !manual_rst
		|-> ##1 {rts2_oe, rts2_out} == $past(apb_req.pwdata[7:6], 2)) else $error("request-to-send pin wrong");
	a_reserved_read_zero: assert property (pready && !apb_req.pwrite && apb_req.paddr == pgs_pkg::OFS_SERIAL_ONE
		|-> prdata[31:8] == 24'h000000 && prdata[6:4] == 3'h0) else $error("reserved bits not zero");
	a_manual_clears_ctrl: assert property (manual_rst |-> ##2 !sck1_oe && !txd1_oe && !error_irq_only_select)
		else $error("manual reset left control bits");
	a_manual_keeps_en: assert property (manual_rst && !$past(pready) |=> $stable(lower_irq_mode))
		else $error("manual reset changed enables");
	a_unmapped_err: assert property (pready && apb_req.paddr >= 8'h10 |-> pslverr && prdata == 32'h00000000)
		else $error("unmapped access not refused");
endmodule
bind pgs_top pgs_top_asserts #(.PORT_W(PORT_W)) u_chk (.clock(clock), .rst(rst), .manual_rst(manual_rst),
	.apb_req(apb_req), .pready(pready), .prdata(prdata), .pslverr(pslverr), .pin_in(pin_in),
	.upper_pin_out(upper_pin_out), .lower_irq_mode(lower_irq_mode), .pin_irq(pin_irq),
	.receive_irq_req(receive_irq_req), .receive_irq(receive_irq), .error_irq_only_select(error_irq_only_select),
	.sck1_out(sck1_out), .sck1_oe(sck1_oe), .txd1_out(txd1_out), .txd1_oe(txd1_oe),
	.rts2_out(rts2_out), .rts2_oe(rts2_oe));

// ---- verification/pgs_pin_model.sv ----
// Pin model: resolves each shared pin from the block's drive and a far-side level.
// Assumes an undriven pin follows the level the bench sets for the far side.
`timescale 1ns/1ns
module pgs_pin_model (
	// Block drive
	input  wire logic [15:0]          upper_out,
	input  wire logic [15:0]          upper_oe,
	input  wire logic [3:0]           ser_out,   // sck1, rts2, cts2, sck2
	input  wire logic [3:0]           ser_oe,
	// Far-side levels and resolved pins
	input  wire pgs_pkg::pgs_pin_in_t ext,
	output pgs_pkg::pgs_pin_in_t      pin_in
);
	// Driven bits take the block's value, others the far side's
	always_comb begin
		pin_in = ext;
		pin_in.upper_pin = (upper_oe & upper_out) | (~upper_oe & ext.upper_pin);
		pin_in.sck1_pin = ser_oe[3] ? ser_out[3] : ext.sck1_pin;
		pin_in.rts2_pin = ser_oe[2] ? ser_out[2] : ext.rts2_pin;
		pin_in.cts2_pin = ser_oe[1] ? ser_out[1] : ext.cts2_pin;
		pin_in.sck2_pin = ser_oe[0] ? ser_out[0] : ext.sck2_pin;
	end
endmodule

// ---- verification/port_b_gpio_irq_serial_pins_tb_top.sv ----
// Testbench for the port block: register traffic, pin levels, interrupts and resets.
// Assumes the pin model resolves pins and the checker is bound into the design.
`timescale 1ns/1ns
module port_b_gpio_irq_serial_pins_tb_top;
	logic                  clock = 1'b0;    // Bench clock
	logic                  rst = 1'b1;      // Power-on reset
	logic                  manual_rst = 1'b0;
	logic                  rx_req = 1'b0;   // Serial receive request
	logic [15:0]           upper_dir = 16'h0000;
	pgs_pkg::pgs_apb_req_t req = '0;
	pgs_pkg::pgs_pin_in_t  ext = '1;        // Far-side pin levels
	pgs_pkg::pgs_pin_in_t  pin_in;
	logic                  pready, pslverr, pin_irq, receive_irq, err_only, err;
	logic [31:0]           prdata, rd, v, m, p;
	logic [15:0]           upper_pin_out, upper_pin_oe, lower_irq_mode;
	logic                  sck1_out, sck1_oe, txd1_out, txd1_oe, rts2_out, rts2_oe, cts2_out, cts2_oe;
	logic                  sck2_out, sck2_oe, txd2_out, txd2_oe;
	int                    n_mismatch = 0;
	int                    total_checks = 0;
	// Clock
	always #10 clock = ~clock;
	pgs_top i_dut (.clock(clock), .rst(rst), .manual_rst(manual_rst), .apb_req(req), .pready(pready),
		.prdata(prdata), .pslverr(pslverr), .pin_in(pin_in), .upper_dir(upper_dir), .upper_pin_out(upper_pin_out),
		.upper_pin_oe(upper_pin_oe), .lower_irq_mode(lower_irq_mode), .pin_irq(pin_irq), .receive_irq_req(rx_req),
		.receive_irq(receive_irq), .error_irq_only_select(err_only), .sck1_out(sck1_out), .sck1_oe(sck1_oe),
		.txd1_out(txd1_out), .txd1_oe(txd1_oe), .rts2_out(rts2_out), .rts2_oe(rts2_oe), .cts2_out(cts2_out),
		.cts2_oe(cts2_oe), .sck2_out(sck2_out), .sck2_oe(sck2_oe), .txd2_out(txd2_out), .txd2_oe(txd2_oe));
	pgs_pin_model i_pins (.upper_out(upper_pin_out), .upper_oe(upper_pin_oe),
		.ser_out({sck1_out, rts2_out, cts2_out, sck2_out}), .ser_oe({sck1_oe, rts2_oe, cts2_oe, sck2_oe}),
		.ext(ext), .pin_in(pin_in));
	// One comparison
	task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
		total_checks++;
		if (g !== e) begin
			n_mismatch++;
			$display("MISMATCH %s expected %h seen %h", nm, e, g);
		end
	endtask
	// One bus transfer, entered just after a rising edge; psel stays up for back-to-back use
	task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d, output logic [31:0] r);
		int n;
		n = 0;
		req.psel <= 1'b1;
		req.penable <= 1'b0;
		req.pwrite <= wr;
		req.paddr <= a;
		req.pwdata <= d;
		req.pstrb <= 4'hF;
		@(posedge clock);
		req.penable <= 1'b1;
		do begin
			@(posedge clock);
			n++;
		end while (pready !== 1'b1);
		r = prdata;
		err = pslverr;
		chk("pready_wait", 32'h00000001, n);
	endtask
	// Release the bus and let cycles pass
	task automatic idle(input int n);
		req.psel <= 1'b0;
		req.penable <= 1'b0;
		repeat (n) @(posedge clock);
	endtask
	// Expected upper read: latch on outputs, pin on inputs
	function automatic logic [15:0] exp_upper(logic [15:0] d, logic [15:0] dir, logic [15:0] pin);
		return (d & dir) | (pin & ~dir);
	endfunction
	// Expected serial one read
	function automatic logic [31:0] exp_sp1(logic [31:0] w, logic sck, logic rxd);
		return {24'h0, w[7], 3'h0, w[3], w[3] ? w[2] : sck, w[1], rxd};
	endfunction
	// Summary and verdict
	task automatic give_verdict();
		$display("checks %0d mismatches %0d", total_checks, n_mismatch);
		if (n_mismatch == 0 && total_checks > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask
	// Watchdog
	initial begin
		repeat (6000) @(posedge clock);
		n_mismatch++;
		give_verdict();
	end
	// Main sequence
	initial begin
		void'($urandom(32'h83E9));
		repeat (12) @(posedge clock);
		rst <= 1'b0;
		@(posedge clock);
		apb(0, pgs_pkg::OFS_PIN_IRQ_EN, 32'h0, rd);
		chk("en_rst", 32'h00000000, rd);
		apb(0, pgs_pkg::OFS_SERIAL_ONE, 32'h0, rd);
		chk("sp1_rst", 32'h00000005, rd);
		apb(0, pgs_pkg::OFS_SERIAL_TWO, 32'h0, rd);
		chk("sp2_rst", 32'h00000055, rd);
		idle(1);
		$display("test reset values done");
		for (int i = 0; i < 10; i++) begin
			v = $urandom;
			m = (i == 0) ? 32'h0 : (i == 1) ? 32'hFFFF : $urandom;
			p = $urandom;
			ext.upper_pin <= p[15:0];
			upper_dir <= m[15:0];
			apb(1, pgs_pkg::OFS_UPPER_LATCH, v, rd);
			idle(6);
			apb(0, pgs_pkg::OFS_UPPER_LATCH, 32'h0, rd);
			chk("upper_rd", exp_upper(v[15:0], m[15:0], p[15:0]), rd[15:0]);
			chk("upper_pin", v[15:0] & m[15:0], upper_pin_out & upper_pin_oe);
			chk("upper_oe", m[15:0], upper_pin_oe);
		end
		idle(1);
		$display("test upper latch done");
		for (int i = 0; i < 10; i++) begin
			m = (i == 0) ? 32'hFFFF : (i == 2) ? 32'h0 : $urandom & 32'hFFFF;
			p = (i == 0) ? 32'hFFFF : (i < 3) ? 32'h0 : $urandom;
			ext.lower_pin <= p[15:0];
			apb(1, pgs_pkg::OFS_PIN_IRQ_EN, m, rd);
			idle(8);
			chk("pin_irq", {31'h0, |(m[15:0] & ~p[15:0])}, {31'h0, pin_irq});
			apb(0, pgs_pkg::OFS_PIN_IRQ_EN, 32'h0, rd);
			chk("en_rd", m, rd);
			chk("irq_mode", m, {16'h0, lower_irq_mode});
		end
		idle(1);
		$display("test pin interrupt done");
		rx_req <= 1'b1;
		for (int i = 0; i < 16; i++) begin
			v = ($urandom & 32'h80) | i;
			m = $urandom & 32'hFF;
			p = $urandom;
			ext.sck1_pin <= p[0];
			ext.rxd1_pin <= p[1];
			{ext.rts2_pin, ext.cts2_pin, ext.sck2_pin, ext.rxd2_pin} <= p[5:2];
			apb(1, pgs_pkg::OFS_SERIAL_ONE, v, rd);
			apb(1, pgs_pkg::OFS_SERIAL_TWO, m, rd);
			idle(6);
			chk("sp1_pins", v[3:0], {sck1_oe, sck1_out, txd1_oe, txd1_out});
			chk("rx_irq", {31'h0, !v[7]}, {31'h0, receive_irq});
			chk("err_only", {31'h0, v[7]}, {31'h0, err_only});
			chk("rts_cts2", m[7:4], {rts2_oe, rts2_out, cts2_oe, cts2_out});
			chk("sck_txd2", m[3:0], {sck2_oe, sck2_out, txd2_oe, txd2_out});
			apb(0, pgs_pkg::OFS_SERIAL_ONE, 32'h0, rd);
			chk("sp1_rd", exp_sp1(v, p[0], p[1]), rd);
			apb(0, pgs_pkg::OFS_SERIAL_TWO, 32'h0, rd);
			chk("sp2_rd", {24'h0, m[7], m[7] ? m[6] : p[5], m[5], m[5] ? m[4] : p[4],
				m[3], m[3] ? m[2] : p[3], m[1], p[2]}, rd);
			idle(1);
		end
		$display("test serial ports done");
		upper_dir <= 16'hFFFF;
		apb(1, pgs_pkg::OFS_PIN_IRQ_EN, 32'hA5C3, rd);
		apb(1, pgs_pkg::OFS_UPPER_LATCH, 32'h3C5A, rd);
		apb(1, pgs_pkg::OFS_SERIAL_ONE, 32'h8A, rd);
		apb(1, pgs_pkg::OFS_SERIAL_TWO, 32'hAA, rd);
		idle(6);
		manual_rst <= 1'b1;
		@(posedge clock);
		manual_rst <= 1'b0;
		idle(6);
		apb(0, pgs_pkg::OFS_PIN_IRQ_EN, 32'h0, rd);
		chk("en_mrst", 32'h0000A5C3, rd);
		apb(0, pgs_pkg::OFS_UPPER_LATCH, 32'h0, rd);
		chk("upper_mrst", 32'h3C5A, rd[15:0]);
		apb(0, pgs_pkg::OFS_SERIAL_ONE, 32'h0, rd);
		chk("sp1_mrst", 32'h0, rd & 32'h8A);
		apb(0, pgs_pkg::OFS_SERIAL_TWO, 32'h0, rd);
		chk("sp2_mrst", 32'h0, rd & 32'hAA);
		idle(1);
		rst <= 1'b1;
		repeat (4) @(posedge clock);
		rst <= 1'b0;
		@(posedge clock);
		apb(0, pgs_pkg::OFS_PIN_IRQ_EN, 32'h0, rd);
		chk("en_por", 32'h0, rd);
		apb(0, pgs_pkg::OFS_UPPER_LATCH, 32'h0, rd);
		chk("upper_por", 32'h3C5A, rd[15:0]);
		apb(1, 8'h10, 32'hFFFF, rd);
		chk("unmapped_wr", 32'h1, {31'h0, err});
		apb(0, 8'h10, 32'h0, rd);
		chk("unmapped_rd", 32'h1, {31'h0, err});
		chk("unmapped_data", 32'h0, rd);
		idle(1);
		$display("test resets and refusal done");
		give_verdict();
	end
endmodule
